/* File: rtl/sspd_pkg.sv */
// Shared constants and types for the sanitize and security-in decoder
package sspd_pkg;
    localparam logic [7:0] OP_SANITIZE = 8'h48;
    localparam logic [7:0] OP_SEC_IN = 8'ha2;
    localparam logic [4:0] SA_OVERWRITE = 5'h01;
    localparam logic [4:0] SA_CRYPT_ERASE = 5'h03;
    localparam logic [4:0] SA_EXIT_FAIL = 5'h1f;
    localparam int SAN_IMMED_BIT = 7;
    localparam int SAN_EXIT_ALLOW_BIT = 5;
    localparam int SIN_INC512_BIT = 7;
    localparam int OVW_INVERT_BIT = 7;
    localparam int OVW_HDR_LAST = 3;
    localparam int INC512_SHIFT = 9;
    localparam logic [7:0] PROTO_INFO = 8'h00;
    localparam logic [7:0] PROTO_EXT_FIRST = 8'h01;
    localparam logic [7:0] PROTO_EXT_LAST = 8'h06;
    localparam logic [3:0] KEY_NONE = 4'h0;
    localparam logic [3:0] KEY_HW_ERROR = 4'h4;
    localparam logic [3:0] KEY_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_INV_CDB = 8'h24;
    localparam logic [7:0] ASC_INV_PARM = 8'h26;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    localparam logic [7:0] PI_FILL = 8'hff;
    localparam logic [4:0] RST_COUNT = 5'h00;
    localparam logic [15:0] RST_LEN = 16'h0000;

    typedef logic [11:0][7:0] sspd_cdb_t;

    typedef struct packed {
        logic check;
        logic [3:0] key;
        logic [7:0] asc;
    } sspd_status_t;

    typedef struct packed {
        logic pi;
        logic [7:0] data;
    } sspd_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_PAT = 2'b11,
        ST_RUN = 2'b10
    } sspd_state_t;
endpackage : sspd_pkg

/* File: rtl/sspd_fill.sv */
// Overwrite byte generator: pattern repeat, protection fill, pass inversion
`timescale 1ns/1ps
`default_nettype none
module sspd_fill #(
    parameter int BLK_LEN = 512,
    parameter int PI_LEN = 8,
    parameter int BLKS_W = 32,
    parameter int PW = 9
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [4:0] passes,
    input wire logic invert,
    input wire logic [15:0] pat_len,
    input wire logic [BLKS_W-1:0] num_blocks,
    output logic [PW-1:0] pat_idx,
    input wire logic [7:0] pat_byte,
    output logic wr_valid,
    output var sspd_pkg::sspd_wr_t wr,
    input wire logic wr_ready,
    output logic done
);
    localparam int BW = $clog2(BLK_LEN + PI_LEN + 1);
    localparam logic [BW-1:0] LAST_B = BW'(BLK_LEN + PI_LEN - 1);
    localparam logic [BW-1:0] DATA_END = BW'(BLK_LEN);
    localparam logic [BLKS_W-1:0] ONE_BLK = 1;

    logic run_r;
    logic [4:0] pass_r;
    logic [BLKS_W-1:0] blk_r;
    logic [BW-1:0] byte_r;
    logic [PW-1:0] pidx_r;
    logic step, flip, is_pi, last_byte, last_blk, last_pass;

    assign step = run_r && (!wr_valid || wr_ready);
    assign flip = invert && pass_r[0];
    assign is_pi = byte_r >= DATA_END;
    assign last_byte = byte_r == LAST_B;
    assign last_blk = blk_r == num_blocks - ONE_BLK;
    assign last_pass = pass_r == 5'(passes - 5'h01);
    assign pat_idx = pidx_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= 1'b0;
            pass_r <= sspd_pkg::RST_COUNT;
            blk_r <= '0;
            byte_r <= '0;
            pidx_r <= '0;
        end else if (start) begin
            run_r <= 1'b1;
            pass_r <= sspd_pkg::RST_COUNT;
            blk_r <= '0;
            byte_r <= '0;
            pidx_r <= '0;
        end else if (abort) begin
            run_r <= 1'b0;
        end else if (step) begin
            byte_r <= last_byte ? '0 : BW'(byte_r + 1'b1);
            if (last_byte) begin
                pidx_r <= '0;
            end else if (!is_pi) begin
                pidx_r <= (pidx_r == PW'(pat_len - 16'h0001)) ? '0 : PW'(pidx_r + 1'b1);
            end
            if (last_byte) begin
                if (last_blk) begin
                    blk_r <= '0;
                    if (last_pass) begin
                        run_r <= 1'b0;
                    end else begin
                        pass_r <= 5'(pass_r + 5'h01);
                    end
                end else begin
                    blk_r <= BLKS_W'(blk_r + ONE_BLK);
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_valid <= 1'b0;
            wr <= '0;
            done <= 1'b0;
        end else begin
            done <= step && last_byte && last_blk && last_pass && !start && !abort;
            if (abort || start) begin
                wr_valid <= 1'b0;
            end else if (step) begin
                wr_valid <= 1'b1;
                wr.pi <= is_pi;
                wr.data <= (is_pi ? sspd_pkg::PI_FILL : pat_byte) ^ {8{flip}};
            end else if (wr_ready) begin
                wr_valid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    pi_all_ones_a: assert property (step && is_pi && !flip && !start && !abort |=> wr.data == 8'hff)
        else $error("protection byte not all ones");
    pi_inverted_a: assert property (step && is_pi && flip && !start && !abort |=> wr.data == 8'h00)
        else $error("protection byte not inverted on odd pass");
    blk_first_a: assert property (step && !start && !abort && byte_r == '0 |=>
        wr.data == ($past(pat_byte) ^ {8{$past(flip)}}) && $past(pat_idx) == '0)
        else $error("block does not begin with pattern first byte");
    cover_pass_wrap_c: cover property (step && last_byte && last_blk && !last_pass);
endmodule : sspd_fill
`default_nettype wire

/* File: rtl/sspd_decoder.sv */
// Sanitize and security-protocol-in command decoder with overwrite engine
// Summary of operation
// - Reserved sanitize service action gives check, illegal request, invalid CDB field.
// - Service action 01h overwrites the medium with a pattern for one or more passes.
// - Service action 03h replaces the encryption key, making old data unreadable.
// - Exit-failure clears sanitize-failed only if the failed sanitize allowed exit.
// - Exit-failure is rejected when the failed sanitize had exit allow clear.
// - Immediate clear returns status at completion; set returns good status at once.
// - Header: invert bit 7 and count in byte 0, length bytes 2-3, pattern at 4.
// - Invert set complements pattern and protection bytes between consecutive passes.
// - Pass count gives number of passes; count zero is reserved.
// - Pattern length zero or above block length gives invalid parameter list field.
// - Pattern repeats to fill each block, each block starting at pattern byte zero.
// - Protection bytes are written as all ones during overwrite, as 00h on inverted passes.
// - Security-in byte 1: 00h info, 01h-06h external, 07h-FFh reserved.
// - Block-unit flag set: allocation length counts 512-byte units, pads are 00h.
// - Block-unit flag clear: allocation length is a plain byte count.
// - With no results ready, report that there is nothing further to transfer.
// - Results kept until read by same nexus, unit reset, or sender nexus loss.
`timescale 1ns/1ps
`default_nettype none
module sspd_decoder #(
    parameter int LBLK_LEN = 512,
    parameter int PI_LEN = 8,
    parameter int BLKS_W = 32
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire sspd_pkg::sspd_cdb_t CMD_CDB,
    input wire logic [7:0] CMD_NEXUS,
    input wire logic PARM_VALID,
    input wire logic [7:0] PARM_BYTE,
    output logic PARM_READY,
    output logic BUSY,
    output logic STAT_VALID,
    output var sspd_pkg::sspd_status_t STAT,
    output logic SAN_FAILED,
    output logic KEY_CHANGE,
    input wire logic MEDIA_FAIL,
    input wire logic [BLKS_W-1:0] NUM_BLOCKS,
    output logic WR_VALID,
    output var sspd_pkg::sspd_wr_t WR,
    input wire logic WR_READY,
    input wire logic RES_STORE,
    input wire logic [7:0] RES_NEXUS,
    input wire logic LU_RESET,
    input wire logic NEXUS_LOSS,
    input wire logic [7:0] LOSS_NEXUS,
    output logic SPIN_VALID,
    output logic SPIN_PROTO_INFO,
    output logic SPIN_PROTO_EXT,
    output logic SPIN_HAS_DATA,
    output logic [40:0] SPIN_XFER_BYTES,
    output logic [7:0] SPIN_PAD
);
    localparam int PW = $clog2(LBLK_LEN);
    localparam logic [15:0] BLK_LEN16 = 16'(LBLK_LEN);

    function automatic sspd_pkg::sspd_status_t mk_stat(input logic chk, input logic [3:0] key,
                                                      input logic [7:0] asc);
        sspd_pkg::sspd_status_t s;
        s.check = chk;
        s.key = key;
        s.asc = asc;
        return s;
    endfunction : mk_stat

    sspd_pkg::sspd_state_t state_r;
    logic immed_r, exit_allow_r, invert_r, failed_r, fail_allow_r, fill_go_r;
    logic [4:0] count_r;
    logic [15:0] len_r;
    logic [1:0] hdr_r;
    logic [PW-1:0] wr_idx_r;
    logic [7:0] pat_mem_r [LBLK_LEN];
    logic res_valid_r;
    logic [7:0] res_nexus_r;
    logic take, san_cmd, sin_cmd, hdr_end, pat_end, parm_err, fill_done, run_fail;
    logic exit_ok, proto_info, proto_ext, sin_match, deliver;
    logic [4:0] sa;
    logic [7:0] proto;
    logic [15:0] len_full;
    logic [31:0] alloc;
    logic [PW-1:0] pat_idx;

    assign take = CMD_VALID && state_r == sspd_pkg::ST_IDLE;
    assign san_cmd = take && CMD_CDB[0] == sspd_pkg::OP_SANITIZE;
    assign sin_cmd = take && CMD_CDB[0] == sspd_pkg::OP_SEC_IN;
    assign sa = CMD_CDB[1][4:0];
    assign exit_ok = failed_r && fail_allow_r;
    assign PARM_READY = state_r == sspd_pkg::ST_HDR || state_r == sspd_pkg::ST_PAT;
    assign BUSY = state_r != sspd_pkg::ST_IDLE;
    assign SAN_FAILED = failed_r;
    assign hdr_end = state_r == sspd_pkg::ST_HDR && PARM_VALID && hdr_r == 2'(sspd_pkg::OVW_HDR_LAST);
    assign len_full = {len_r[15:8], PARM_BYTE};
    assign parm_err = len_full == 16'h0000 || len_full > BLK_LEN16 || count_r == 5'h00;
    assign pat_end = state_r == sspd_pkg::ST_PAT && PARM_VALID && wr_idx_r == PW'(len_r - 16'h0001);
    assign run_fail = state_r == sspd_pkg::ST_RUN && MEDIA_FAIL;
    assign proto = CMD_CDB[1];
    assign proto_info = proto == sspd_pkg::PROTO_INFO;
    assign proto_ext = proto >= sspd_pkg::PROTO_EXT_FIRST && proto <= sspd_pkg::PROTO_EXT_LAST;
    assign alloc = {CMD_CDB[6], CMD_CDB[7], CMD_CDB[8], CMD_CDB[9]};
    assign sin_match = res_valid_r && res_nexus_r == CMD_NEXUS;
    assign deliver = sin_cmd && proto_ext && sin_match;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_r <= sspd_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                sspd_pkg::ST_IDLE: if (san_cmd && sa == sspd_pkg::SA_OVERWRITE) begin
                    state_r <= sspd_pkg::ST_HDR;
                end
                sspd_pkg::ST_HDR: if (hdr_end) begin
                    state_r <= parm_err ? sspd_pkg::ST_IDLE : sspd_pkg::ST_PAT;
                end
                sspd_pkg::ST_PAT: if (pat_end) begin
                    state_r <= sspd_pkg::ST_RUN;
                end
                sspd_pkg::ST_RUN: if (fill_done || MEDIA_FAIL) begin
                    state_r <= sspd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            immed_r <= 1'b0;
            exit_allow_r <= 1'b0;
            invert_r <= 1'b0;
            count_r <= sspd_pkg::RST_COUNT;
            len_r <= sspd_pkg::RST_LEN;
            hdr_r <= 2'h0;
        end else if (san_cmd) begin
            immed_r <= CMD_CDB[1][sspd_pkg::SAN_IMMED_BIT];
            exit_allow_r <= CMD_CDB[1][sspd_pkg::SAN_EXIT_ALLOW_BIT];
            hdr_r <= 2'h0;
        end else if (state_r == sspd_pkg::ST_HDR && PARM_VALID) begin
            hdr_r <= 2'(hdr_r + 2'h1);
            unique case (hdr_r)
                2'h0: begin
                    invert_r <= PARM_BYTE[sspd_pkg::OVW_INVERT_BIT];
                    count_r <= PARM_BYTE[4:0];
                end
                2'h2: len_r[15:8] <= PARM_BYTE;
                2'h3: len_r <= len_full;
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            wr_idx_r <= '0;
            fill_go_r <= 1'b0;
        end else begin
            fill_go_r <= pat_end;
            if (hdr_end) begin
                wr_idx_r <= '0;
            end else if (state_r == sspd_pkg::ST_PAT && PARM_VALID) begin
                wr_idx_r <= PW'(wr_idx_r + 1'b1);
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (state_r == sspd_pkg::ST_PAT && PARM_VALID) begin
            pat_mem_r[wr_idx_r] <= PARM_BYTE;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            STAT_VALID <= 1'b0;
            STAT <= '0;
        end else begin
            STAT_VALID <= 1'b0;
            if (san_cmd) begin
                if (sa == sspd_pkg::SA_CRYPT_ERASE || (sa == sspd_pkg::SA_EXIT_FAIL && exit_ok)) begin
                    STAT_VALID <= 1'b1;
                    STAT <= mk_stat(1'b0, sspd_pkg::KEY_NONE, sspd_pkg::ASC_NONE);
                end else if (sa != sspd_pkg::SA_OVERWRITE) begin
                    STAT_VALID <= 1'b1;
                    STAT <= mk_stat(1'b1, sspd_pkg::KEY_ILLEGAL, sspd_pkg::ASC_INV_CDB);
                end
            end else if (sin_cmd) begin
                STAT_VALID <= 1'b1;
                STAT <= (proto_info || proto_ext) ?
                    mk_stat(1'b0, sspd_pkg::KEY_NONE, sspd_pkg::ASC_NONE) :
                    mk_stat(1'b1, sspd_pkg::KEY_ILLEGAL, sspd_pkg::ASC_INV_CDB);
            end else if (hdr_end && parm_err) begin
                STAT_VALID <= 1'b1;
                STAT <= mk_stat(1'b1, sspd_pkg::KEY_ILLEGAL, sspd_pkg::ASC_INV_PARM);
            end else if (pat_end && immed_r) begin
                STAT_VALID <= 1'b1;
                STAT <= mk_stat(1'b0, sspd_pkg::KEY_NONE, sspd_pkg::ASC_NONE);
            end else if (run_fail && !immed_r) begin
                STAT_VALID <= 1'b1;
                STAT <= mk_stat(1'b1, sspd_pkg::KEY_HW_ERROR, sspd_pkg::ASC_NONE);
            end else if (state_r == sspd_pkg::ST_RUN && fill_done && !immed_r) begin
                STAT_VALID <= 1'b1;
                STAT <= mk_stat(1'b0, sspd_pkg::KEY_NONE, sspd_pkg::ASC_NONE);
            end
        end
    end

    // A failure in the same cycle as completion still leaves the failed state set
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            failed_r <= 1'b0;
            fail_allow_r <= 1'b0;
            KEY_CHANGE <= 1'b0;
        end else begin
            KEY_CHANGE <= san_cmd && sa == sspd_pkg::SA_CRYPT_ERASE;
            if (run_fail) begin
                failed_r <= 1'b1;
                fail_allow_r <= exit_allow_r;
            end else if ((san_cmd && sa == sspd_pkg::SA_EXIT_FAIL && exit_ok) ||
                         (san_cmd && sa == sspd_pkg::SA_CRYPT_ERASE) ||
                         (state_r == sspd_pkg::ST_RUN && fill_done)) begin
                failed_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            res_valid_r <= 1'b0;
            res_nexus_r <= 8'h00;
        end else if (RES_STORE) begin
            res_valid_r <= 1'b1;
            res_nexus_r <= RES_NEXUS;
        end else if (deliver || LU_RESET || (NEXUS_LOSS && LOSS_NEXUS == res_nexus_r)) begin
            res_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            SPIN_VALID <= 1'b0;
            SPIN_PROTO_INFO <= 1'b0;
            SPIN_PROTO_EXT <= 1'b0;
            SPIN_HAS_DATA <= 1'b0;
            SPIN_XFER_BYTES <= '0;
            SPIN_PAD <= sspd_pkg::PAD_BYTE;
        end else begin
            SPIN_VALID <= sin_cmd && (proto_info || proto_ext);
            if (sin_cmd) begin
                SPIN_PROTO_INFO <= proto_info;
                SPIN_PROTO_EXT <= proto_ext;
                SPIN_HAS_DATA <= proto_info || deliver;
                SPIN_PAD <= sspd_pkg::PAD_BYTE;
                SPIN_XFER_BYTES <= CMD_CDB[4][sspd_pkg::SIN_INC512_BIT] ?
                    {alloc, 9'h000} : {9'h000, alloc};
            end
        end
    end

    sspd_fill #(.BLK_LEN(LBLK_LEN), .PI_LEN(PI_LEN), .BLKS_W(BLKS_W), .PW(PW)) u_fill (
        .clk(REF_CLK),
        .rst(RST),
        .start(fill_go_r),
        .abort(run_fail),
        .passes(count_r),
        .invert(invert_r),
        .pat_len(len_r),
        .num_blocks(NUM_BLOCKS),
        .pat_idx(pat_idx),
        .pat_byte(pat_mem_r[pat_idx]),
        .wr_valid(WR_VALID),
        .wr(WR),
        .wr_ready(WR_READY),
        .done(fill_done)
    );

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    reserved_sa_a: assert property (san_cmd && sa != sspd_pkg::SA_OVERWRITE &&
        sa != sspd_pkg::SA_CRYPT_ERASE && sa != sspd_pkg::SA_EXIT_FAIL |=>
        STAT_VALID && STAT.check && STAT.key == 4'h5 && STAT.asc == 8'h24)
        else $error("reserved service action not rejected");
    overwrite_entry_a: assert property (san_cmd && sa == 5'h01 |=> PARM_READY && !STAT_VALID)
        else $error("overwrite did not open parameter list");
    crypt_key_a: assert property (san_cmd && sa == 5'h03 |=> KEY_CHANGE && !SAN_FAILED)
        else $error("cryptographic erase did not change key");
    exit_accept_a: assert property (san_cmd && sa == 5'h1f && failed_r && fail_allow_r &&
        !MEDIA_FAIL |=> !SAN_FAILED && STAT_VALID && !STAT.check)
        else $error("allowed exit-failure not accepted");
    exit_reject_a: assert property (san_cmd && sa == 5'h1f && !(failed_r && fail_allow_r) |=>
        STAT_VALID && STAT.check && $stable(SAN_FAILED))
        else $error("disallowed exit-failure not rejected");
    immed_status_a: assert property (pat_end && immed_r |=> STAT_VALID && !STAT.check
        ##1 (!STAT_VALID)[*2])
        else $error("immediate good status not returned once");
    patlen_check_a: assert property (hdr_end && len_full == 16'h0000 |=>
        STAT_VALID && STAT.asc == 8'h26 && !BUSY)
        else $error("zero pattern length not rejected");
    count_zero_a: assert property (hdr_end && count_r == 5'h00 |=> !BUSY && STAT.check)
        else $error("zero pass count accepted");
    sin_units_a: assert property (sin_cmd && CMD_CDB[4][7] |=>
        SPIN_XFER_BYTES == 41'($past(alloc)) * 41'd512)
        else $error("512-byte units not applied");
    sin_bytes_a: assert property (sin_cmd && !CMD_CDB[4][7] |=>
        SPIN_XFER_BYTES == 41'($past(alloc)))
        else $error("plain byte allocation altered");
    sin_nodata_a: assert property (sin_cmd && proto_ext && !sin_match |=>
        SPIN_VALID && !SPIN_HAS_DATA)
        else $error("missing results reported as data");
    retain_a: assert property (res_valid_r && !RES_STORE && !deliver && !LU_RESET && !NEXUS_LOSS |=>
        res_valid_r && $stable(res_nexus_r))
        else $error("stored results dropped without cause");
    cover_overwrite_c: cover property (state_r == sspd_pkg::ST_RUN && fill_done);
    cover_exit_c: cover property (san_cmd && sa == 5'h1f && exit_ok);
    cover_deliver_c: cover property (deliver);
endmodule : sspd_decoder
`default_nettype wire

/* File: bench/sspd_sink.sv */
// Medium-side write sink: takes overwrite beats promptly or with random stalls
`timescale 1ns/1ps
`default_nettype none
module sspd_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    output logic ready
);
    integer seed = 4;
    always @(posedge clk or posedge rst) begin
        if (rst) ready <= 1'b0;
        else ready <= !stall || (($random(seed) & 1) == 1);
    end
endmodule : sspd_sink
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the sanitize and security-in decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int LB = 8;
    localparam int PL = 2;
    localparam logic [12:0] BAD_CDB = {1'b1, sspd_pkg::KEY_ILLEGAL, sspd_pkg::ASC_INV_CDB};
    localparam logic [12:0] BAD_PRM = {1'b1, sspd_pkg::KEY_ILLEGAL, sspd_pkg::ASC_INV_PARM};
    localparam logic [12:0] MFAIL = {1'b1, sspd_pkg::KEY_HW_ERROR, sspd_pkg::ASC_NONE};
    logic clk = 1'b0, rst = 1'b1, cv = 1'b0, pv = 1'b0, mf = 1'b0, stall = 1'b0;
    logic rs = 1'b0, lur = 1'b0, nl = 1'b0;
    logic [31:0] nb = 32'h2;
    sspd_pkg::sspd_cdb_t cdb = '0;
    logic [7:0] nex = 8'h00, pb = 8'h00, lnex = 8'h00;
    logic pr, busy, sv, sf, kc, wv, wrr, spv, spi, spe, sph;
    sspd_pkg::sspd_status_t stat, lst;
    sspd_pkg::sspd_wr_t wr;
    logic [40:0] xfer;
    logic [7:0] pad;
    logic [8:0] q[$];
    logic [7:0] pat[8];
    int errors = 0, checked = 0, nst = 0, nsp = 0, nkc = 0;
    integer seed = 4;
    always #12.5 clk = ~clk;
    sspd_decoder #(.LBLK_LEN(LB), .PI_LEN(PL), .BLKS_W(32)) i_sspd_decoder (
        .REF_CLK(clk), .RST(rst), .CMD_VALID(cv), .CMD_CDB(cdb), .CMD_NEXUS(nex),
        .PARM_VALID(pv), .PARM_BYTE(pb), .PARM_READY(pr), .BUSY(busy), .STAT_VALID(sv),
        .STAT(stat), .SAN_FAILED(sf), .KEY_CHANGE(kc), .MEDIA_FAIL(mf),
        .NUM_BLOCKS(nb), .WR_VALID(wv), .WR(wr), .WR_READY(wrr), .RES_STORE(rs),
        .RES_NEXUS(8'h05), .LU_RESET(lur), .NEXUS_LOSS(nl), .LOSS_NEXUS(lnex),
        .SPIN_VALID(spv), .SPIN_PROTO_INFO(spi), .SPIN_PROTO_EXT(spe),
        .SPIN_HAS_DATA(sph), .SPIN_XFER_BYTES(xfer), .SPIN_PAD(pad));
    sspd_sink i_sspd_sink (.clk(clk), .rst(rst), .stall(stall), .ready(wrr));
    always @(posedge clk) begin
        if (sv) lst <= stat;
        if (sv) nst <= nst + 1;
        if (kc) nkc <= nkc + 1;
        if (spv) nsp <= nsp + 1;
        if (wv && wrr) q.push_back(wr);
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc
    task automatic cmd(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b4,
                       input logic [31:0] al, input logic [7:0] nx);
        cdb = '0;
        cdb[0] = op;
        cdb[1] = b1;
        cdb[4] = b4;
        {cdb[6], cdb[7], cdb[8], cdb[9]} = al;
        nex = nx;
        cv = 1'b1;
        cyc(1);
        cv = 1'b0;
        cyc(2);
    endtask : cmd
    task automatic pbyte(input logic [7:0] b);
        pv = 1'b1;
        pb = b;
        for (int i = 0; i < 20 && !pr; i++) cyc(1);
        cyc(1);
    endtask : pbyte
    function automatic logic [8:0] exp_beat(input int p, input int i, input logic inv,
                                            input int len);
        logic [8:0] e;
        e = (i < LB) ? {1'b0, pat[i % len]} : 9'h1ff;
        if (inv && p % 2 == 1) e = e ^ 9'h0ff;
        return e;
    endfunction : exp_beat
    task automatic ovw(input logic imm, input logic inv, input logic [4:0] cnt,
                       input logic [15:0] len, input logic alw, input logic fail);
        int s0;
        s0 = nst;
        q.delete();
        cmd(8'h48, {imm, 1'b0, alw, sspd_pkg::SA_OVERWRITE}, 8'h00, 32'h0, 8'h01);
        chk(pr, 1'b1);
        pbyte({inv, 2'b00, cnt});
        pbyte(8'h00);
        pbyte(len[15:8]);
        pbyte(len[7:0]);
        if (len == 0 || len > LB || cnt == 0) begin
            pv = 1'b0;
            cyc(2);
            chk(lst, BAD_PRM);
            chk(busy, 1'b0);
            return;
        end
        for (int i = 0; i < len; i++) pbyte(pat[i]);
        pv = 1'b0;
        cyc(2);
        chk(nst - s0, imm);
        if (fail) begin
            cyc(5);
            mf = 1'b1;
            cyc(1);
            mf = 1'b0;
            cyc(2);
            chk(sf, 1'b1);
            chk(busy, 1'b0);
            if (!imm) chk(lst, MFAIL);
            return;
        end
        for (int k = 0; k < 3000 && busy; k++) cyc(1);
        cyc(10);
        chk(q.size(), cnt * nb * (LB + PL));
        for (int k = 0; k < q.size(); k++)
            chk(q[k], exp_beat(k / (int'(nb) * (LB + PL)), k % (LB + PL), inv, len));
        chk(nst - s0, 1);
        chk(lst, 13'h0000);
        chk(sf, 1'b0);
    endtask : ovw
    task automatic sin(input logic [7:0] pr0, input logic [7:0] nx, input logic hd);
        cmd(8'ha2, pr0, 8'h00, 32'h10, nx);
        chk(sph, hd);
    endtask : sin
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    initial begin
        #(25 * 20000);
        errors++;
        final_report;
    end
    initial begin
        for (int i = 0; i < 8; i++) pat[i] = 8'($random(seed));
        cyc(10);
        rst = 1'b0;
        cyc(1);
        for (int sa = 0; sa < 31; sa++) begin
            if (sa != 1 && sa != 3) cmd(8'h48, 8'(sa), 8'h00, 32'h0, 8'h01);
            if (sa != 1 && sa != 3) chk(lst, BAD_CDB);
        end
        cmd(8'h48, 8'h1f, 8'h00, 32'h0, 8'h01);
        chk(lst, BAD_CDB);
        cmd(8'h48, 8'h03, 8'h00, 32'h0, 8'h01);
        chk(nkc, 1);
        chk(lst, 13'h0000);
        $display("service action test done");
        ovw(1'b0, 1'b1, 5'h03, 16'h0003, 1'b0, 1'b0);
        stall = 1'b1;
        ovw(1'b1, 1'b1, 5'h02, 16'(LB), 1'b0, 1'b0);
        for (int t = 0; t < 3; t++) begin
            nb = 32'(1 + ($random(seed) & 3));
            ovw(1'b0, 1'($random(seed)), 5'(1 + ($random(seed) & 3)),
                16'(1 + ($random(seed) & 7)), 1'b0, 1'b0);
        end
        nb = 32'h2;
        ovw(1'b0, 1'b0, 5'h01, 16'h0000, 1'b0, 1'b0);
        ovw(1'b0, 1'b0, 5'h01, 16'(LB + 1), 1'b0, 1'b0);
        ovw(1'b0, 1'b0, 5'h00, 16'h0004, 1'b0, 1'b0);
        $display("overwrite test done");
        ovw(1'b0, 1'b0, 5'h01, 16'h0004, 1'b0, 1'b1);
        cmd(8'h48, 8'h1f, 8'h00, 32'h0, 8'h01);
        chk(lst, BAD_CDB);
        chk(sf, 1'b1);
        ovw(1'b1, 1'b0, 5'h01, 16'h0004, 1'b1, 1'b1);
        cmd(8'h48, 8'h1f, 8'h00, 32'h0, 8'h01);
        chk(lst, 13'h0000);
        chk(sf, 1'b0);
        $display("failure recovery test done");
        cmd(8'ha2, 8'h00, 8'h80, 32'h3, 8'h01);
        chk({spi, sph, xfer, pad}, {2'b11, 41'd1536, 8'h00});
        cmd(8'ha2, 8'h00, 8'h00, 32'h1234, 8'h01);
        chk(xfer, 41'h1234);
        sin(8'h02, 8'h05, 1'b0);
        chk(spe, 1'b1);
        rs = 1'b1;
        cyc(1);
        rs = 1'b0;
        sin(8'h02, 8'h06, 1'b0);
        sin(8'h02, 8'h05, 1'b1);
        sin(8'h02, 8'h05, 1'b0);
        rs = 1'b1;
        cyc(1);
        rs = 1'b0;
        lur = 1'b1;
        cyc(1);
        lur = 1'b0;
        sin(8'h02, 8'h05, 1'b0);
        for (int l = 5; l < 8; l += 2) begin
            rs = 1'b1;
            cyc(1);
            rs = 1'b0;
            nl = 1'b1;
            lnex = 8'(l);
            cyc(1);
            nl = 1'b0;
            sin(8'h06, 8'h05, l != 5);
        end
        for (int p = 7; p < 256; p += 124) begin
            int n0;
            n0 = nsp;
            cmd(8'ha2, 8'(p), 8'h00, 32'h10, 8'h05);
            chk(lst, BAD_CDB);
            chk(nsp - n0, 0);
        end
        $display("security-in test done");
        final_report;
    end
endmodule : tb_top
`default_nettype wire
